// *** hw/wrtb_top.sv ***
// watchdog down-counter and real-time timebase with apb register slave
module wrtb_top #(
  parameter int DIV0 = wrtb_pkg::TB_DIV0,
  parameter int DIV1 = wrtb_pkg::TB_DIV1,
  parameter int DIV2 = wrtb_pkg::TB_DIV2,
  parameter int DIV3 = wrtb_pkg::TB_DIV3,
  parameter int WDG_PRE = wrtb_pkg::WDG_PRESCALE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_wdg_opt,
  input wire logic cpu_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_exec,
  input wire logic halt_wake_irq,
  output logic wdg_reset,
  output logic tb_irq_req,
  output logic irq,
  output logic wakeup,
  output logic [1:0] power_mode
);

  // ---------------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] idx);
    hit = (addr == {idx[9:0], 2'b00});
  endfunction : hit

  function automatic logic [17:0] div_last(input logic [1:0] sel);
    unique case (sel)
      2'b00: div_last = 18'(DIV0 - 1);
      2'b01: div_last = 18'(DIV1 - 1);
      2'b10: div_last = 18'(DIV2 - 1);
      2'b11: div_last = 18'(DIV3 - 1);
    endcase
  endfunction : div_last

  wrtb_pkg::wrtb_state_s st;
  wrtb_pkg::wrtb_state_s next_st;

  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic wr_wdg;
  logic wr_clk;
  logic rd_clk;
  logic regs_live;
  logic wdg_running;
  logic wdg_tick;
  logic tb_wrap;
  logic [6:0] wdg_new;

  // ---------------------------------------------------------------------------
  // apb slave: zero wait state, unmapped addresses answer with an error
  // ---------------------------------------------------------------------------
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign mapped = hit(paddr, wrtb_pkg::WDG_CTRL_IDX) || hit(paddr, wrtb_pkg::CLK_STAT_IDX)
    || hit(paddr, wrtb_pkg::IRQ_STAT_IDX) || hit(paddr, wrtb_pkg::IRQ_MASK_IDX);
  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata = st.prdata;

  // watchdog and clock status registers are frozen outside run mode; writes to them simply get no effect then
  assign regs_live = (st.pmode == wrtb_pkg::WRTB_RUN); // [RL12] [RL13]
  assign wr_wdg = access_ph && pwrite && regs_live && hit(paddr, wrtb_pkg::WDG_CTRL_IDX);
  assign wr_clk = access_ph && pwrite && regs_live && hit(paddr, wrtb_pkg::CLK_STAT_IDX);
  assign rd_clk = access_ph && !pwrite && regs_live && hit(paddr, wrtb_pkg::CLK_STAT_IDX);

  // ---------------------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------------------
  // full halt stops the watchdog so it cannot bite while the oscillator is parked
  assign wdg_running = (st.wdg_act || hw_wdg_opt) && (st.pmode == wrtb_pkg::WRTB_RUN); // [RL2]
  assign wdg_tick = wdg_running && (st.wdg_pre == 14'(WDG_PRE - 1)); // [RL3]
  assign tb_wrap = (st.pmode != wrtb_pkg::WRTB_HALT) && (st.tb_cnt == div_last(st.tb_sel_act));
  assign wdg_new = wr_wdg ? pwdata[6:0] : (wdg_tick ? st.wdg_cnt - 7'h01 : st.wdg_cnt);

  always_comb begin
    next_st = st;
    next_st.wdg_rst = 1'b0;
    next_st.wakeup = 1'b0;
    // watchdog
    // the prescaler wraps at the parameter, not at its own 14-bit limit
    if (wdg_tick) begin
      next_st.wdg_pre = 14'h0000; // [RL3]
    end else if (wdg_running) begin
      next_st.wdg_pre = 14'(st.wdg_pre + 14'h0001); // [RL3]
    end
    if (wr_wdg && pwdata[wrtb_pkg::WDG_ACT_BIT]) begin
      next_st.wdg_act = 1'b1; // [RL1] [RL17]
    end
    next_st.wdg_cnt = wdg_new; // [RL17]
    // top bit falling while live forces the reset, whether by count or by a bad write
    if ((st.wdg_act || hw_wdg_opt || (wr_wdg && pwdata[wrtb_pkg::WDG_ACT_BIT]))
        && st.wdg_cnt[wrtb_pkg::WDG_TOP_BIT] && !wdg_new[wrtb_pkg::WDG_TOP_BIT]) begin
      next_st.wdg_rst = 1'b1; // [RL4] [RL16]
      next_st.irq_sts[wrtb_pkg::EV_WDG_BIT] = 1'b1;
    end
    // timebase counter runs in wait and clock running stop, stops in full halt
    if (st.pmode != wrtb_pkg::WRTB_HALT) begin // [RL11] [RL12] [RL13]
      next_st.tb_cnt = tb_wrap ? 18'h00000 : 18'(st.tb_cnt + 18'h00001);
    end
    if (wr_clk) begin
      next_st.tb_sel = pwdata[wrtb_pkg::TB_SEL_LSB +: 2];
      next_st.tb_ie = pwdata[wrtb_pkg::TB_IE_BIT];
    end
    if (tb_wrap) begin
      next_st.tb_sel_act = wr_clk ? pwdata[wrtb_pkg::TB_SEL_LSB +: 2] : st.tb_sel; // [RL6] [RL7]
    end
    // read clears the flag, but a period end in the same cycle wins
    if (rd_clk) begin
      next_st.tb_flag = 1'b0; // [RL8]
    end
    if (tb_wrap) begin
      next_st.tb_flag = 1'b1; // [RL8]
      next_st.irq_sts[wrtb_pkg::EV_TB_BIT] = 1'b1;
    end
    // interrupt status: write one to clear, a new event in the same cycle wins
    if (access_ph && pwrite && hit(paddr, wrtb_pkg::IRQ_STAT_IDX)) begin
      next_st.irq_sts = (st.irq_sts & ~pwdata[1:0])
        | {next_st.wdg_rst, tb_wrap};
    end
    if (access_ph && pwrite && hit(paddr, wrtb_pkg::IRQ_MASK_IDX)) begin
      next_st.irq_msk = pwdata[1:0];
    end
    // power modes
    unique case (st.pmode)
      wrtb_pkg::WRTB_RUN: begin
        if (halt_exec) begin
          next_st.pmode = st.tb_ie ? wrtb_pkg::WRTB_ACT_HALT : wrtb_pkg::WRTB_HALT; // [RL10]
        end
        if (wait_mode && tb_wrap && st.tb_ie) begin
          next_st.wakeup = 1'b1; // [RL11]
        end
      end
      wrtb_pkg::WRTB_ACT_HALT: begin
        if (halt_wake_irq || (tb_wrap && st.tb_ie)) begin
          next_st.pmode = wrtb_pkg::WRTB_RUN; // [RL12]
          next_st.wakeup = 1'b1;
        end
      end
      wrtb_pkg::WRTB_HALT: begin
        if (halt_wake_irq) begin
          next_st.pmode = wrtb_pkg::WRTB_RUN; // [RL13]
          next_st.wakeup = 1'b1;
        end
      end
      default: begin
        next_st.pmode = wrtb_pkg::WRTB_RUN;
      end
    endcase
    // read data captured in setup so it stands through the access phase
    if (setup_ph) begin
      next_st.prdata = 32'h00000000;
      if (hit(paddr, wrtb_pkg::WDG_CTRL_IDX)) begin
        next_st.prdata[7:0] = {st.wdg_act, st.wdg_cnt}; // [RL5]
      end
      if (hit(paddr, wrtb_pkg::CLK_STAT_IDX)) begin
        next_st.prdata[7:0] = {4'h0, st.tb_sel, st.tb_ie, st.tb_flag}; // [RL14]
      end
      if (hit(paddr, wrtb_pkg::IRQ_STAT_IDX)) begin
        next_st.prdata[1:0] = st.irq_sts;
      end
      if (hit(paddr, wrtb_pkg::IRQ_MASK_IDX)) begin
        next_st.prdata[1:0] = st.irq_msk;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.wdg_act <= wrtb_pkg::WDG_CTRL_RST[wrtb_pkg::WDG_ACT_BIT];
      st.wdg_cnt <= wrtb_pkg::WDG_CTRL_RST[6:0]; // [RL5]
      st.tb_sel <= wrtb_pkg::CLK_STAT_RST[wrtb_pkg::TB_SEL_LSB +: 2]; // [RL14]
      st.tb_sel_act <= wrtb_pkg::CLK_STAT_RST[wrtb_pkg::TB_SEL_LSB +: 2];
      st.tb_ie <= wrtb_pkg::CLK_STAT_RST[wrtb_pkg::TB_IE_BIT];
      st.tb_flag <= wrtb_pkg::CLK_STAT_RST[wrtb_pkg::TB_FLAG_BIT];
      st.pmode <= wrtb_pkg::WRTB_RUN;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign wdg_reset = st.wdg_rst;
  assign tb_irq_req = st.tb_flag && st.tb_ie && !cpu_irq_mask; // [RL9]
  assign irq = |(st.irq_sts & st.irq_msk);
  assign wakeup = st.wakeup;
  assign power_mode = st.pmode;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_clk_read;
    ce && rd_clk && !tb_wrap;
  endsequence

  sequence s_wdg_setup_read;
    ce && setup_ph && hit(paddr, wrtb_pkg::WDG_CTRL_IDX);
  endsequence

  sequence s_clk_setup_read;
    ce && setup_ph && hit(paddr, wrtb_pkg::CLK_STAT_IDX);
  endsequence

  sequence s_crs_wrap;
    ce && st.pmode == wrtb_pkg::WRTB_ACT_HALT && tb_wrap && st.tb_ie;
  endsequence

  property p_wdg_sticky;
    st.wdg_act |=> st.wdg_act;
  endproperty
  a_wdg_sticky: assert property (p_wdg_sticky) else $error("activation bit cleared"); // [RL1]

  property p_hw_runs;
    ce && hw_wdg_opt && regs_live && !wdg_tick |=> st.wdg_pre == 14'($past(st.wdg_pre) + 1);
  endproperty
  a_hw_runs: assert property (p_hw_runs) else $error("hardware watchdog not counting"); // [RL2]

  property p_wdg_dec;
    ce && wdg_tick && !wr_wdg |=> st.wdg_cnt == 7'($past(st.wdg_cnt) - 1) && st.wdg_pre == 14'h0;
  endproperty
  a_wdg_dec: assert property (p_wdg_dec) else $error("watchdog count not decremented"); // [RL3]

  property p_wdg_bite;
    ce && wdg_tick && !wr_wdg && st.wdg_cnt == 7'h40 |=> wdg_reset ##1 !wdg_reset;
  endproperty
  a_wdg_bite: assert property (p_wdg_bite) else $error("no reset on 40h to 3Fh"); // [RL4]

  property p_wdg_read;
    s_wdg_setup_read |=> prdata[7:0] == {$past(st.wdg_act), $past(st.wdg_cnt)} && pready;
  endproperty
  a_wdg_read: assert property (p_wdg_read) else $error("watchdog register read wrong"); // [RL5]

  property p_sel_hold;
    ce && !tb_wrap |=> $stable(st.tb_sel_act);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("timebase changed mid period"); // [RL7]

  property p_period;
    ce && tb_wrap |=> st.tb_flag && st.tb_cnt == 18'h0;
  endproperty
  a_period: assert property (p_period) else $error("period end missed"); // [RL6]

  property p_flag_clear;
    s_clk_read |=> !st.tb_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("read did not clear flag"); // [RL8]

  property p_irq_gate;
    ce && tb_wrap && !wr_clk && st.tb_ie |=> st.tb_flag && tb_irq_req == !cpu_irq_mask;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("timebase request ungated"); // [RL9]

  property p_active_halt;
    ce && halt_exec && regs_live |=> power_mode == ($past(st.tb_ie) ? 2'h1 : 2'h2);
  endproperty
  a_active_halt: assert property (p_active_halt) else $error("wrong halt mode"); // [RL10]

  property p_crs_count;
    ce && st.pmode == wrtb_pkg::WRTB_ACT_HALT |=> st.tb_cnt != $past(st.tb_cnt);
  endproperty
  a_crs_count: assert property (p_crs_count) else $error("counter stopped in active halt"); // [RL12]

  property p_halt_frozen;
    ce && st.pmode == wrtb_pkg::WRTB_HALT && !halt_wake_irq |=> $stable(st.tb_cnt) && !wakeup;
  endproperty
  a_halt_frozen: assert property (p_halt_frozen) else $error("timebase moved in halt"); // [RL13]

  property p_wdg_idle;
    ce && !wdg_running |=> st.wdg_pre == $past(st.wdg_pre);
  endproperty
  a_wdg_idle: assert property (p_wdg_idle) else $error("prescaler moved while idle"); // [RL3]

  property p_wdg_load;
    ce && wr_wdg |=> st.wdg_cnt == $past(pwdata[6:0]);
  endproperty
  a_wdg_load: assert property (p_wdg_load) else $error("count not loaded by write"); // [RL17]

  property p_wdg_set;
    ce && wr_wdg && pwdata[wrtb_pkg::WDG_ACT_BIT] |=> st.wdg_act;
  endproperty
  a_wdg_set: assert property (p_wdg_set) else $error("activation not set by write"); // [RL17]

  property p_wdg_quiet;
    ce && !st.wdg_act && !hw_wdg_opt && !wr_wdg |=> !wdg_reset;
  endproperty
  a_wdg_quiet: assert property (p_wdg_quiet) else $error("reset while disabled"); // [RL1]

  property p_bad_write;
    ce && wr_wdg && (st.wdg_act || hw_wdg_opt) && st.wdg_cnt[wrtb_pkg::WDG_TOP_BIT]
      && !pwdata[wrtb_pkg::WDG_TOP_BIT] |=> wdg_reset;
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("cleared top bit gave no reset"); // [RL16]

  property p_wdg_pulse;
    ce && wdg_reset |=> !wdg_reset;
  endproperty
  a_wdg_pulse: assert property (p_wdg_pulse) else $error("watchdog reset too long"); // [RL4]

  property p_halt_wdg;
    ce && st.pmode != wrtb_pkg::WRTB_RUN |=> $stable(st.wdg_cnt) && $stable(st.wdg_act);
  endproperty
  a_halt_wdg: assert property (p_halt_wdg) else $error("watchdog moved in halt"); // [RL13]

  property p_regs_frozen;
    ce && !regs_live |=> $stable(st.tb_sel) && $stable(st.tb_ie);
  endproperty
  a_regs_frozen: assert property (p_regs_frozen) else $error("register moved while frozen"); // [RL12]

  property p_sel_load;
    ce && tb_wrap && !wr_clk |=> st.tb_sel_act == $past(st.tb_sel);
  endproperty
  a_sel_load: assert property (p_sel_load) else $error("select not taken at period end"); // [RL7]

  property p_clk_read;
    s_clk_setup_read |=> prdata == {28'h0000000, $past(st.tb_sel), $past(st.tb_ie),
      $past(st.tb_flag)};
  endproperty
  a_clk_read: assert property (p_clk_read) else $error("clock register read wrong"); // [RL14]

  property p_halt_stay;
    ce && st.pmode == wrtb_pkg::WRTB_HALT && !halt_wake_irq
      |=> st.pmode == wrtb_pkg::WRTB_HALT;
  endproperty
  a_halt_stay: assert property (p_halt_stay) else $error("left halt without wake"); // [RL13]

  property p_crs_wake;
    s_crs_wrap |=> wakeup && st.pmode == wrtb_pkg::WRTB_RUN;
  endproperty
  a_crs_wake: assert property (p_crs_wake) else $error("period end did not wake"); // [RL12]

  property p_wait_wake;
    ce && regs_live && wait_mode && tb_wrap && st.tb_ie |=> wakeup;
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("no wake from wait"); // [RL11]

  property p_tb_run;
    ce && regs_live && !tb_wrap |=> st.tb_cnt == 18'($past(st.tb_cnt) + 1);
  endproperty
  a_tb_run: assert property (p_tb_run) else $error("timebase stalled in run"); // [RL11]

endmodule : wrtb_top

// *** include/wrtb_pkg.sv ***
// package: constants, register map and state carrier for the watchdog and timebase block
// ---------------------------------------------------------------------------
// Operation
// RL1 - activation bit is set by software, cleared only by system reset
// RL2 - hardware watchdog option keeps the watchdog running, activation bit ignored
// RL3 - 7-bit count decrements once every 16384 oscillator cycles while active
// RL4 - watchdog reset fires when the count rolls from 40h to 3Fh
// RL5 - watchdog control register at index 0024h, resets to 7Fh
// RL6 - timebase select picks divide by 16000, 32000, 80000 or 200000
// RL7 - a new timebase select applies only when the current period ends
// RL8 - period end sets the timebase flag; reading the status register clears it
// RL9 - timebase interrupt needs enable set and cpu interrupt mask inactive
// RL10 - halt with timebase interrupt enabled enters clock running stop mode
// RL11 - wait mode leaves the timebase running; its interrupt wakes from wait
// RL12 - in clock running stop the counter runs, registers frozen, interrupt wakes
// RL13 - full halt freezes counter and registers; timebase interrupt cannot wake it
// RL14 - clock status register at index 0026h, resets to 00h, bits 7:4 zero
// RL15 - software avoids bit set or clear instructions on the clock status register
// RL16 - software always writes one to the count top bit
// RL17 - watchdog write loads the count and sets activation when bit 7 is one
// ---------------------------------------------------------------------------
package wrtb_pkg;

  // ---------------------------------------------------------------------------
  // register map: indices, byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [11:0] WDG_CTRL_IDX = 12'h024;
  localparam logic [11:0] CLK_STAT_IDX = 12'h026;
  localparam logic [11:0] IRQ_STAT_IDX = 12'h028;
  localparam logic [11:0] IRQ_MASK_IDX = 12'h029;

  localparam logic [7:0] WDG_CTRL_RST = 8'h7F;
  localparam logic [7:0] CLK_STAT_RST = 8'h00;

  // clock status fields
  localparam int TB_FLAG_BIT = 0;
  localparam int TB_IE_BIT = 1;
  localparam int TB_SEL_LSB = 2;
  // watchdog control fields
  localparam int WDG_ACT_BIT = 7;
  localparam int WDG_TOP_BIT = 6;
  // interrupt status fields
  localparam int EV_TB_BIT = 0;
  localparam int EV_WDG_BIT = 1;

  // ---------------------------------------------------------------------------
  // timing counts in oscillator cycles
  // ---------------------------------------------------------------------------
  localparam int WDG_PRESCALE = 16384;
  localparam int TB_DIV0 = 16000;
  localparam int TB_DIV1 = 32000;
  localparam int TB_DIV2 = 80000;
  localparam int TB_DIV3 = 200000;

  typedef enum logic [1:0] {
    WRTB_RUN = 2'b00,
    WRTB_ACT_HALT = 2'b01,
    WRTB_HALT = 2'b10
  } wrtb_pmode_e;

  typedef struct packed {
    logic wdg_act;
    logic [6:0] wdg_cnt;
    logic [13:0] wdg_pre;
    logic wdg_rst;
    logic [1:0] tb_sel;
    logic [1:0] tb_sel_act;
    logic tb_ie;
    logic tb_flag;
    logic [17:0] tb_cnt;
    logic [1:0] irq_sts;
    logic [1:0] irq_msk;
    wrtb_pmode_e pmode;
    logic wakeup;
    logic [31:0] prdata;
  } wrtb_state_s;

endpackage : wrtb_pkg

// *** test/wrtb_top_bench.sv ***
// testbench: registers, timebase periods, power modes and watchdog of wrtb_top
module wrtb_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------
  // design and clock
  // --------------------
  // short divider counts keep the run brief; every period expectation comes from DV
  localparam int DV [4] = '{8, 12, 16, 20};
  localparam logic [11:0] A_WDG = {wrtb_pkg::WDG_CTRL_IDX[9:0], 2'b00};
  localparam logic [11:0] A_CLK = {wrtb_pkg::CLK_STAT_IDX[9:0], 2'b00};
  localparam logic [11:0] A_STS = {wrtb_pkg::IRQ_STAT_IDX[9:0], 2'b00};
  localparam logic [11:0] A_MSK = {wrtb_pkg::IRQ_MASK_IDX[9:0], 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic hw_wdg_opt = 1'b0;
  logic cpu_irq_mask = 1'b0;
  logic wait_mode = 1'b0;
  logic halt_exec = 1'b0;
  logic halt_wake_irq = 1'b0;
  logic ce = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, wdg_reset, tb_irq_req, irq, wakeup;
  logic [1:0] power_mode;
  logic [31:0] rd, wd;
  logic er;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int wk = 0;
  int wdr = 0;
  int n, t0, act_div, pend_div;
  wrtb_top #(.DIV0(DV[0]), .DIV1(DV[1]), .DIV2(DV[2]), .DIV3(DV[3]), .WDG_PRE(16)) u_wrtb_top (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .hw_wdg_opt, .cpu_irq_mask, .wait_mode, .halt_exec, .halt_wake_irq, .wdg_reset,
    .tb_irq_req, .irq, .wakeup, .power_mode
  );
  initial begin
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wakeup === 1'b1) wk <= wk + 1;
    if (wdg_reset === 1'b1) wdr <= wdr + 1;
  end
  // --------------------
  // shared tasks
  // --------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  // upper data bits are random: only the low byte may matter
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= ($urandom() & 32'hFFFFFF00) | d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      chk("pready timeout", 32'h1, 32'h0);
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  // 0 timebase request, 1 watchdog reset, else wakeup; n holds the edges waited
  task automatic wait_for(input int s, input int lim);
    logic v;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      v = (s == 0) ? tb_irq_req : (s == 1) ? wdg_reset : wakeup;
    end while (v !== 1'b1 && n < lim);
    if (v !== 1'b1) begin
      chk("event timeout", 32'h1, 32'h0);
      print_verdict();
    end
  endtask : wait_for
  task automatic pulse(input logic wake);
    @(posedge pclk);
    if (wake) halt_wake_irq <= 1'b1;
    else halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    halt_wake_irq <= 1'b0;
  endtask : pulse
  // --------------------
  // scenarios
  // --------------------
  initial begin
    void'($urandom(70));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_WDG, 32'h7F, "wdg reset value");
    rdchk(A_CLK, 32'h00, "clk reset value");
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
    wr(A_CLK, 32'h2);
    apb(1'b0, A_CLK, 32'h0);
    wait_for(0, 64);
    t0 = cyc;
    act_div = DV[0];
    // model: the running period is act_div, a written select waits in pend_div
    for (int c = 0; c < 5; c++) begin
      if (c < 4) begin
        wr(A_CLK, 32'(c * 4 + 2) | 32'hF0);
        pend_div = DV[c];
        rdchk(A_CLK, 32'(c * 4 + 3), "clk flag set");
      end else begin
        apb(1'b0, A_CLK, 32'h0);
      end
      wait_for(0, 64);
      chk("period", 32'(act_div), 32'(cyc - t0));
      t0 = cyc;
      act_div = pend_div;
    end
    cpu_irq_mask <= 1'b1;
    repeat (25) @(posedge pclk);
    chk("masked req", 32'h0, 32'(tb_irq_req));
    rdchk(A_CLK, 32'hF, "flag while masked");
    cpu_irq_mask <= 1'b0;
    wr(A_MSK, 32'h1);
    @(posedge pclk);
    chk("irq raised", 32'h1, 32'(irq));
    wr(A_MSK, 32'h0);
    @(posedge pclk);
    chk("irq masked", 32'h0, 32'(irq));
    // with the clock enable low the mask write must be lost
    ce <= 1'b0;
    wr(A_MSK, 32'h1);
    @(posedge pclk);
    chk("ce freeze", 32'h0, 32'(irq));
    ce <= 1'b1;
    wr(A_MSK, 32'h1);
    $display("test timebase done");
    // sync to a period start so the halt entry is not raced by a period end
    wr(A_CLK, 32'hE);
    apb(1'b0, A_CLK, 32'h0);
    wait_for(0, 64);
    apb(1'b0, A_CLK, 32'h0);
    pulse(1'b0);
    @(posedge pclk);
    chk("active halt", 32'h1, 32'(power_mode));
    wr(A_CLK, 32'h2);
    wait_for(2, 64);
    @(posedge pclk);
    chk("run again", 32'h0, 32'(power_mode));
    apb(1'b0, A_CLK, 32'h0);
    chk("frozen regs", 32'hE, rd & 32'hFE);
    wr(A_CLK, 32'h0);
    apb(1'b0, A_CLK, 32'h0);
    pulse(1'b0);
    @(posedge pclk);
    chk("full halt", 32'h2, 32'(power_mode));
    t0 = wk;
    wr(A_CLK, 32'h2);
    wr(A_STS, 32'h3);
    rdchk(A_STS, 32'h0, "status cleared");
    chk("irq cleared", 32'h0, 32'(irq));
    repeat (60) @(posedge pclk);
    chk("no wake", 32'(t0), 32'(wk));
    chk("still halted", 32'h2, 32'(power_mode));
    pulse(1'b1);
    wait_for(2, 4);
    @(posedge pclk);
    chk("halt exit", 32'h0, 32'(power_mode));
    apb(1'b0, A_CLK, 32'h0);
    chk("halt frozen regs", 32'h0, rd & 32'hFE);
    wr(A_CLK, 32'h2);
    wait_mode <= 1'b1;
    wait_for(2, 64);
    wait_mode <= 1'b0;
    $display("test power done");
    wd = 32'($urandom_range(127, 64));
    wr(A_WDG, wd);
    repeat (40) @(posedge pclk);
    rdchk(A_WDG, wd, "wdg idle count");
    chk("no wdg reset", 32'h0, 32'(wdr));
    wr(A_WDG, 32'h41);
    hw_wdg_opt <= 1'b1;
    wait_for(1, 40);
    chk("hw opt timing", 32'h1, 32'(n >= 16 && n <= 36));
    hw_wdg_opt <= 1'b0;
    wr(A_WDG, 32'hC1);
    wait_for(1, 40);
    chk("wdg timing", 32'h1, 32'(n >= 16 && n <= 36));
    apb(1'b0, A_STS, 32'h0);
    chk("wdg event", 32'h2, rd & 32'h2);
    wr(A_WDG, 32'h7F);
    apb(1'b0, A_WDG, 32'h0);
    chk("act sticky", 32'h80, rd & 32'h80);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_WDG, 32'h7F, "act cleared");
    rdchk(A_CLK, 32'h00, "clk after reset");
    $display("test watchdog done");
    print_verdict();
  end
endmodule : wrtb_top_bench
